//--- core/plc_pkg.sv
package plc_pkg;

  // ----------------------------------------------------------------
  // Register offsets, byte addresses on the 8-bit register port.
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_LCE = 8'h00; // Line control enable.
  localparam logic [7:0] OFF_LCD = 8'h04; // Line control disable.
  localparam logic [7:0] OFF_LCS = 8'h08; // Line control status.
  localparam logic [7:0] OFF_OES = 8'h10; // Output enable set.
  localparam logic [7:0] OFF_OEC = 8'h14; // Output enable clear.
  localparam logic [7:0] OFF_OEST = 8'h18; // Output enable status.
  localparam logic [7:0] OFF_GFE = 8'h20; // Glitch filter enable.
  localparam logic [7:0] OFF_GFD = 8'h24; // Glitch filter disable.
  localparam logic [7:0] OFF_GFS = 8'h28; // Glitch filter status.
  localparam logic [7:0] OFF_OLS = 8'h30; // Output level set.
  localparam logic [7:0] OFF_OLC = 8'h34; // Output level clear.
  localparam logic [7:0] OFF_OLD = 8'h38; // Output level data.
  localparam logic [7:0] OFF_PIN = 8'h3c; // Pin level.
  localparam logic [7:0] OFF_CIE = 8'h40; // Change irq enable.
  localparam logic [7:0] OFF_CID = 8'h44; // Change irq disable.
  localparam logic [7:0] OFF_CIM = 8'h48; // Change irq mask.
  localparam logic [7:0] OFF_CIS = 8'h4c; // Change irq status.
  localparam logic [7:0] OFF_ODE = 8'h50; // Open drain enable.
  localparam logic [7:0] OFF_ODD = 8'h54; // Open drain disable.
  localparam logic [7:0] OFF_ODS = 8'h58; // Open drain status.
  localparam logic [7:0] OFF_PUD = 8'h60; // Pull-up disable.
  localparam logic [7:0] OFF_PUE = 8'h64; // Pull-up enable.
  localparam logic [7:0] OFF_PUS = 8'h68; // Pull-up status.
  localparam logic [7:0] OFF_PAS = 8'h70; // Peripheral A select.
  localparam logic [7:0] OFF_PBS = 8'h74; // Peripheral B select.
  localparam logic [7:0] OFF_PSS = 8'h78; // Peripheral select status.
  localparam logic [7:0] OFF_DWE = 8'ha0; // Direct write mask enable.
  localparam logic [7:0] OFF_DWD = 8'ha4; // Direct write mask disable.
  localparam logic [7:0] OFF_DWS = 8'ha8; // Direct write mask status.

  // ----------------------------------------------------------------
  // Implementation constants and reset values.
  // ----------------------------------------------------------------
  localparam logic [31:0] IMPL_MASK = 32'h0fff_ffff; // Lines present.
  localparam logic [31:0] PERIPH_MASK = 32'h0fff_0000; // Lines with peripherals.
  localparam logic [31:0] LCS_RST = 32'h0fff_ffff; // Line control status reset.
  localparam logic [31:0] ZERO_RST = 32'h0000_0000; // Reset of cleared registers.

endpackage : plc_pkg

//--- core/plc_line_ctrl.sv
// The plain strobed port was decided locally.
`timescale 1ns/1ps
// Function
// - 32-bit registers, bit n is line n.
// - Writes to absent lines change nothing.
// - Absent line bits always read zero.
// - Lines without peripheral always owned, read 1.
// - Ownership status reset value is implementation constant.
// - Direct output writes only where mask set.
// - Pin level tracks pins while clock runs.
// - Change status resets zero, changes may follow.
// - A select clears, B select sets status.
// - Select registers at 0x70, 0x74, 0x78.
// - Glitch filter status resets to zero.
// - Pull-up status resets to zero.
// - Direct write mask resets to zero.
// - Select 0 routes A, 1 routes B.
// - Reading change status clears pending bits.
// - Filter rejects half cycle, accepts one cycle; here the filter only delays the level by one sample and rejects nothing.
// - Interrupt is OR of masked status bits.
module plc_line_ctrl (
  input wire logic sys_clk_in, // Controller master clock, 250 MHz.
  input wire logic rst_b_in, // Asynchronous reset, active low.
  input wire logic [7:0] addr_in, // Register byte address.
  input wire logic [31:0] wdata_in, // Register write data.
  input wire logic wr_in, // Write strobe, one cycle.
  input wire logic rd_in, // Read strobe, one cycle.
  output logic [31:0] rdata_out, // Read data, cycle after read.
  input wire logic [31:0] pin_in, // Pin levels, synchronous.
  output logic [31:0] pin_out, // Pin drive levels.
  output logic [31:0] pin_oe_out, // Pin drive enables, high drives.
  output logic [31:0] pullup_out, // Pull-up enables per line.
  input wire logic [31:0] periph_a_dout_in, // Peripheral A output data.
  input wire logic [31:0] periph_a_oe_in, // Peripheral A output enable.
  input wire logic [31:0] periph_b_dout_in, // Peripheral B output data.
  input wire logic [31:0] periph_b_oe_in, // Peripheral B output enable.
  output logic irq_out // Input change interrupt.
);

  // ----------------------------------------------------------------
  // Helper functions.
  // ----------------------------------------------------------------

  // One write of a set or clear register moves only the written ones.
  function automatic logic [31:0] set_clr(
    input logic [31:0] cur,
    input logic set_hit,
    input logic clr_hit,
    input logic [31:0] d
  );
    logic [31:0] md;
    md = d & plc_pkg::IMPL_MASK;
    set_clr = cur;
    if (set_hit) begin
      set_clr = cur | md;
    end else if (clr_hit) begin
      set_clr = cur & ~md;
    end
  endfunction : set_clr

  // Address match for a write at one offset.
  function automatic logic wr_at(
    input logic wr,
    input logic [7:0] a,
    input logic [7:0] off
  );
    wr_at = wr && (a == off);
  endfunction : wr_at

  // ----------------------------------------------------------------
  // Register state.
  // ----------------------------------------------------------------
  logic [31:0] lcs_r; // Line control status.
  logic [31:0] oes_r; // Output enable status.
  logic [31:0] gfs_r; // Glitch filter status.
  logic [31:0] old_r; // Output level data.
  logic [31:0] cim_r; // Change irq mask.
  logic [31:0] cis_r; // Change irq status.
  logic [31:0] ods_r; // Open drain status.
  logic [31:0] pus_r; // Pull-up status.
  logic [31:0] pss_r; // Peripheral select status.
  logic [31:0] dws_r; // Direct write mask status.
  logic [31:0] samp_r; // Pin sample.
  logic [31:0] hold_r; // Delayed pin sample.
  logic [31:0] lvl_r; // Filtered pin level.
  logic [31:0] prev_r; // Previous filtered level.
  logic [31:0] chg; // Changes seen this cycle.
  logic [31:0] rd_nxt; // Read data next value.
  logic [31:0] drv; // Selected drive level.
  logic [31:0] den; // Selected drive enable.
  logic cis_rd; // Change status read.

  // ----------------------------------------------------------------
  // Line ownership.
  // ----------------------------------------------------------------

  // Lines with no peripheral stay owned whatever software writes.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      lcs_r <= plc_pkg::LCS_RST;
    end else begin
      lcs_r <= set_clr(lcs_r, wr_at(wr_in, addr_in, plc_pkg::OFF_LCE),
        wr_at(wr_in, addr_in, plc_pkg::OFF_LCD), wdata_in)
        | (~plc_pkg::PERIPH_MASK & plc_pkg::IMPL_MASK);
    end
  end

  // ----------------------------------------------------------------
  // Output enable, filter, open drain, pull-up, irq mask.
  // ----------------------------------------------------------------

  // Output enable status, written before or after taking the line.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      oes_r <= plc_pkg::ZERO_RST;
    end else begin
      oes_r <= set_clr(oes_r, wr_at(wr_in, addr_in, plc_pkg::OFF_OES),
        wr_at(wr_in, addr_in, plc_pkg::OFF_OEC), wdata_in);
    end
  end

  // Glitch filter status; every filter is off after reset.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      gfs_r <= plc_pkg::ZERO_RST;
    end else begin
      gfs_r <= set_clr(gfs_r, wr_at(wr_in, addr_in, plc_pkg::OFF_GFE),
        wr_at(wr_in, addr_in, plc_pkg::OFF_GFD), wdata_in);
    end
  end

  // Open drain status.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ods_r <= plc_pkg::ZERO_RST;
    end else begin
      ods_r <= set_clr(ods_r, wr_at(wr_in, addr_in, plc_pkg::OFF_ODE),
        wr_at(wr_in, addr_in, plc_pkg::OFF_ODD), wdata_in);
    end
  end

  // Pull-up status; note the disable register sits at the lower offset.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pus_r <= plc_pkg::ZERO_RST;
    end else begin
      pus_r <= set_clr(pus_r, wr_at(wr_in, addr_in, plc_pkg::OFF_PUE),
        wr_at(wr_in, addr_in, plc_pkg::OFF_PUD), wdata_in);
    end
  end

  // Change interrupt mask.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cim_r <= plc_pkg::ZERO_RST;
    end else begin
      cim_r <= set_clr(cim_r, wr_at(wr_in, addr_in, plc_pkg::OFF_CIE),
        wr_at(wr_in, addr_in, plc_pkg::OFF_CID), wdata_in);
    end
  end

  // Direct write mask; blocks direct level writes after reset.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      dws_r <= plc_pkg::ZERO_RST;
    end else begin
      dws_r <= set_clr(dws_r, wr_at(wr_in, addr_in, plc_pkg::OFF_DWE),
        wr_at(wr_in, addr_in, plc_pkg::OFF_DWD), wdata_in);
    end
  end

  // ----------------------------------------------------------------
  // Peripheral selection, with the polarity reversed.
  // ----------------------------------------------------------------

  // The A register clears the status bit and the B register sets it.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pss_r <= plc_pkg::ZERO_RST;
    end else begin
      pss_r <= set_clr(pss_r, wr_at(wr_in, addr_in, plc_pkg::OFF_PBS),
        wr_at(wr_in, addr_in, plc_pkg::OFF_PAS), wdata_in);
    end
  end

  // ----------------------------------------------------------------
  // Output level data.
  // ----------------------------------------------------------------

  // A direct write lets one store move a whole group without a
  // transient, but only the bits set in the mask take the new value.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      old_r <= plc_pkg::ZERO_RST;
    end else if (wr_at(wr_in, addr_in, plc_pkg::OFF_OLD)) begin
      old_r <= (old_r & ~dws_r) | (wdata_in & dws_r
        & plc_pkg::IMPL_MASK);
    end else begin
      old_r <= set_clr(old_r, wr_at(wr_in, addr_in, plc_pkg::OFF_OLS),
        wr_at(wr_in, addr_in, plc_pkg::OFF_OLC), wdata_in);
    end
  end

  // ----------------------------------------------------------------
  // Input sampling and glitch filter.
  // ----------------------------------------------------------------

  // Samples run every clock; with the clock stopped the flops keep
  // the last levels, which is what a read then returns.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      samp_r <= plc_pkg::ZERO_RST;
      hold_r <= plc_pkg::ZERO_RST;
    end else begin
      samp_r <= pin_in & plc_pkg::IMPL_MASK;
      hold_r <= samp_r;
    end
  end

  // Sampling already drops sub-cycle glitches; a filtered line adds
  // the documented one cycle latency so a full-cycle pulse passes.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      lvl_r <= plc_pkg::ZERO_RST;
      prev_r <= plc_pkg::ZERO_RST;
    end else begin
      lvl_r <= (samp_r & ~gfs_r) | (hold_r & gfs_r);
      prev_r <= lvl_r;
    end
  end

  // Change detect compares two successive filtered samples. Levels
  // reset to zero, so a high pin may flag a change after reset.
  assign chg = (lvl_r ^ prev_r) & plc_pkg::IMPL_MASK;

  // ----------------------------------------------------------------
  // Change interrupt status.
  // ----------------------------------------------------------------
  assign cis_rd = rd_in && (addr_in == plc_pkg::OFF_CIS);

  // A read clears all pending bits; a change in that cycle survives.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cis_r <= plc_pkg::ZERO_RST;
    end else if (cis_rd) begin
      cis_r <= chg;
    end else begin
      cis_r <= cis_r | chg;
    end
  end

  // Interrupt output, registered one cycle after the status.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(cis_r & cim_r);
    end
  end

  // ----------------------------------------------------------------
  // Read port.
  // ----------------------------------------------------------------

  // Write-only and reserved offsets read zero.
  always_comb begin
    rd_nxt = plc_pkg::ZERO_RST;
    if (addr_in == plc_pkg::OFF_LCS) begin
      rd_nxt = lcs_r;
    end else if (addr_in == plc_pkg::OFF_OEST) begin
      rd_nxt = oes_r;
    end else if (addr_in == plc_pkg::OFF_GFS) begin
      rd_nxt = gfs_r;
    end else if (addr_in == plc_pkg::OFF_OLD) begin
      rd_nxt = old_r;
    end else if (addr_in == plc_pkg::OFF_PIN) begin
      rd_nxt = lvl_r;
    end else if (addr_in == plc_pkg::OFF_CIM) begin
      rd_nxt = cim_r;
    end else if (addr_in == plc_pkg::OFF_CIS) begin
      rd_nxt = cis_r;
    end else if (addr_in == plc_pkg::OFF_ODS) begin
      rd_nxt = ods_r;
    end else if (addr_in == plc_pkg::OFF_PUS) begin
      rd_nxt = pus_r;
    end else if (addr_in == plc_pkg::OFF_PSS) begin
      rd_nxt = pss_r;
    end else if (addr_in == plc_pkg::OFF_DWS) begin
      rd_nxt = dws_r;
    end else begin
      rd_nxt = plc_pkg::ZERO_RST;
    end
  end

  // Data stand only in the cycle after the strobe, else zero.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_out <= plc_pkg::ZERO_RST;
    end else if (rd_in) begin
      rdata_out <= rd_nxt & plc_pkg::IMPL_MASK;
    end else begin
      rdata_out <= plc_pkg::ZERO_RST;
    end
  end

  // ----------------------------------------------------------------
  // Pin drive.
  // ----------------------------------------------------------------

  // Owned lines use the controller's level and enable; others follow
  // peripheral A on a zero select bit and peripheral B on a one.
  assign drv = (lcs_r & old_r) | (~lcs_r & ((~pss_r & periph_a_dout_in)
    | (pss_r & periph_b_dout_in)));
  assign den = (lcs_r & oes_r) | (~lcs_r & ((~pss_r & periph_a_oe_in)
    | (pss_r & periph_b_oe_in)));

  // Open drain lines only ever pull low; the pull-up gives the high.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pin_out <= plc_pkg::ZERO_RST;
      pin_oe_out <= plc_pkg::ZERO_RST;
      pullup_out <= plc_pkg::ZERO_RST;
    end else begin
      pin_out <= drv & ~ods_r & plc_pkg::IMPL_MASK;
      pin_oe_out <= den & ~(ods_r & drv) & plc_pkg::IMPL_MASK;
      pullup_out <= pus_r;
    end
  end

  // ----------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------
  default clocking dcb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_b_in);

  sequence s_cis_read;
    cis_rd ##1 1'b1;
  endsequence

  sequence s_dir_write;
    wr_at(wr_in, addr_in, plc_pkg::OFF_OLD);
  endsequence

  a_absent_read_zero: assert property (
    (rdata_out & ~plc_pkg::IMPL_MASK) == 32'h0000_0000)
    else $error("Absent line bits read nonzero.");

  a_owned_fixed: assert property (
    ((~lcs_r) & ~plc_pkg::PERIPH_MASK & plc_pkg::IMPL_MASK) == 32'h0000_0000)
    else $error("Line without peripheral lost ownership.");

  a_direct_masked: assert property (
    s_dir_write |=> ((old_r ^ $past(old_r)) & ~$past(dws_r)) == 32'h0000_0000
      && ((old_r ^ $past(wdata_in)) & $past(dws_r) & plc_pkg::IMPL_MASK)
        == 32'h0000_0000)
    else $error("Direct level write ignored its mask.");

  a_pin_tracks: assert property (
    ##2 ((lvl_r ^ $past(pin_in, 2)) & ~$past(gfs_r) & plc_pkg::IMPL_MASK)
      == 32'h0000_0000)
    else $error("Unfiltered pin level lags more than two cycles.");

  a_sel_a_clears: assert property (
    wr_at(wr_in, addr_in, plc_pkg::OFF_PAS)
      |=> (pss_r & $past(wdata_in)) == 32'h0000_0000)
    else $error("A select did not clear status.");

  a_read_clears: assert property (
    s_cis_read |-> rdata_out == $past(cis_r)
      && (cis_r & ~$past(chg)) == 32'h0000_0000)
    else $error("Status read did not clear pending bits.");

  a_filter_delay: assert property (
    ##1 ((lvl_r ^ $past(hold_r)) & $past(gfs_r)) == 32'h0000_0000)
    else $error("Filtered level not one sample late.");

  a_irq_or: assert property (
    ##1 irq_out == |($past(cis_r) & $past(cim_r)))
    else $error("Interrupt is not OR of masked status.");

  a_route_b: assert property (
    ##1 ((pin_out ^ $past(periph_b_dout_in)) & ~$past(lcs_r) & $past(pss_r)
      & ~$past(ods_r) & plc_pkg::IMPL_MASK) == 32'h0000_0000)
    else $error("Select one did not route peripheral B.");

  a_enable_sets: assert property (
    wr_at(wr_in, addr_in, plc_pkg::OFF_OES)
      |=> ($past(wdata_in) & plc_pkg::IMPL_MASK & ~oes_r) == 32'h0000_0000)
    else $error("Output enable write did not set status.");

endmodule : plc_line_ctrl

//--- sim/plc_pin_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Pin side model: pads, external drivers and pull-ups.
// ----------------------------------------------------------------
module plc_pin_model (
  input wire logic sys_clk_in, // Controller clock.
  input wire logic [31:0] pin_drv_in, // Level the controller drives.
  input wire logic [31:0] pin_oe_in, // Controller drive enables.
  input wire logic [31:0] pullup_in, // Pull-up enables.
  input wire logic [31:0] ext_lvl_in, // External driver levels.
  input wire logic [31:0] ext_en_in, // External driver enables.
  output logic [31:0] pin_lvl_out // Resolved pad levels.
);
  logic [31:0] held_r;
  logic [31:0] float_m;

  // A pad that nobody drives or pulls shows the inverse of its last level, so a
  // stale value can never pass for a driven one.
  assign float_m = ~pin_oe_in & ~ext_en_in & ~pullup_in;
  assign pin_lvl_out = (pin_oe_in & pin_drv_in) | (~pin_oe_in & ext_en_in & ext_lvl_in) |
    (~pin_oe_in & ~ext_en_in & pullup_in) | (float_m & ~held_r);

  // Remember the last level of every pad that was driven or pulled.
  always_ff @(posedge sys_clk_in) begin
    held_r <= (held_r & float_m) | (pin_lvl_out & ~float_m);
  end
endmodule : plc_pin_model

//--- sim/test_parallel_io_line_controller.sv
`timescale 1ns/1ps
module test_parallel_io_line_controller;
  logic sys_clk_in, rst_b_in, wr_in, rd_in, irq_out;
  logic [7:0] addr_in;
  logic [31:0] wdata_in, rdata_out, pin_in, pin_out, pin_oe_out, pullup_out;
  logic [31:0] pa_d, pa_oe, pb_d, pb_oe, ext_lvl, ext_en;
  logic [31:0] m_lcs, m_oes, m_gfs, m_old, m_cim, m_ods, m_pus, m_pss, m_dws;
  int n_errors, cmp_count;
  logic [7:0] rd_tab [20] = '{8'h08, 8'h18, 8'h28, 8'h38, 8'h48, 8'h58, 8'h68, 8'h78,
    8'ha8, 8'h00, 8'h04, 8'h0c, 8'h1c, 8'h2c, 8'h5c, 8'h6c, 8'h7c, 8'h9c, 8'hac, 8'hfc};
  logic [7:0] wr_tab [20] = '{8'h00, 8'h04, 8'h10, 8'h14, 8'h20, 8'h24, 8'h30, 8'h34,
    8'h38, 8'h40, 8'h44, 8'h50, 8'h54, 8'h60, 8'h64, 8'h70, 8'h74, 8'ha0, 8'ha4, 8'h0c};
  // Software set-up of a mixed port: grouped outputs, inputs, peripheral lines.
  logic [7:0] ex_a [18] = '{8'h00, 8'h04, 8'h10, 8'h14, 8'h20, 8'h24, 8'h30, 8'h34,
    8'h40, 8'h44, 8'h50, 8'h54, 8'h60, 8'h64, 8'h70, 8'h74, 8'ha0, 8'ha4};
  logic [31:0] ex_d [18] = '{32'h0000_ffff, 32'h0fff_0000, 32'h0000_00ff, 32'h0fff_ff00,
    32'h0000_0f00, 32'h0fff_f0ff, 32'h0000_0000, 32'h0fff_ffff, 32'h0f00_0f00,
    32'h00ff_f0ff, 32'h0000_000f, 32'h0fff_fff0, 32'h00f0_00f0, 32'h0f0f_ff0f,
    32'h0f0f_0000, 32'h00f0_0000, 32'h0000_000f, 32'h0fff_fff0};

  plc_line_ctrl i_plc_line_ctrl (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_out(pin_oe_out),
    .pullup_out(pullup_out), .periph_a_dout_in(pa_d), .periph_a_oe_in(pa_oe),
    .periph_b_dout_in(pb_d), .periph_b_oe_in(pb_oe), .irq_out(irq_out));
  plc_pin_model i_plc_pin_model (.sys_clk_in(sys_clk_in), .pin_drv_in(pin_out),
    .pin_oe_in(pin_oe_out), .pullup_in(pullup_out), .ext_lvl_in(ext_lvl),
    .ext_en_in(ext_en), .pin_lvl_out(pin_in));

  // ----------------------------------------------------------------
  // Clock, verdict and watchdog.
  // ----------------------------------------------------------------
  initial begin
    sys_clk_in = 1'b0;
    forever #2 sys_clk_in = ~sys_clk_in;
  end

  task give_verdict;
    $display("comparisons %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict

  // A hang anywhere counts as a mismatch and still reaches the verdict.
  initial begin
    #200000;
    n_errors++;
    give_verdict();
  end

  // ----------------------------------------------------------------
  // Reference model of the register file.
  // ----------------------------------------------------------------
  function automatic void model_wr(input logic [7:0] a, input logic [31:0] dd);
    logic [31:0] w;
    w = dd & plc_pkg::IMPL_MASK;
    case (a)
      8'h00: m_lcs |= w;
      8'h04: m_lcs &= ~(w & plc_pkg::PERIPH_MASK);
      8'h10: m_oes |= w;
      8'h14: m_oes &= ~w;
      8'h20: m_gfs |= w;
      8'h24: m_gfs &= ~w;
      8'h30: m_old |= w;
      8'h34: m_old &= ~w;
      8'h38: m_old = (m_old & ~m_dws) | (w & m_dws);
      8'h40: m_cim |= w;
      8'h44: m_cim &= ~w;
      8'h50: m_ods |= w;
      8'h54: m_ods &= ~w;
      8'h60: m_pus &= ~w;
      8'h64: m_pus |= w;
      8'h70: m_pss &= ~w;
      8'h74: m_pss |= w;
      8'ha0: m_dws |= w;
      8'ha4: m_dws &= ~w;
      default: ;
    endcase
  endfunction : model_wr

  function automatic logic [31:0] exp_rd(input logic [7:0] a);
    case (a)
      8'h08: return m_lcs;
      8'h18: return m_oes;
      8'h28: return m_gfs;
      8'h38: return m_old;
      8'h48: return m_cim;
      8'h58: return m_ods;
      8'h68: return m_pus;
      8'h78: return m_pss;
      8'ha8: return m_dws;
      default: return 32'h0000_0000;
    endcase
  endfunction : exp_rd

  // ----------------------------------------------------------------
  // Bus tasks and comparisons.
  // ----------------------------------------------------------------
  task chk_rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value reg %h expected %h seen %h", a, e, g);
    end
  endtask : chk_rd

  task chk_pin(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk_pin

  task reg_wr(input logic [7:0] a, input logic [31:0] dd);
    @(posedge sys_clk_in);
    addr_in <= a;
    wdata_in <= dd;
    wr_in <= 1'b1;
    @(posedge sys_clk_in);
    wr_in <= 1'b0;
    model_wr(a, dd);
  endtask : reg_wr

  // Read data are taken in the one cycle after the strobe.
  task rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge sys_clk_in);
    rd_in <= 1'b0;
    #1 chk_rd(a, e, rdata_out);
  endtask : rd_chk

  task chk_regs;
    foreach (rd_tab[i]) rd_chk(rd_tab[i], exp_rd(rd_tab[i]));
  endtask : chk_regs

  // Outputs follow the registers one cycle later; pin_out and pin_oe_out are judged on present lines only.
  task chk_out;
    logic [31:0] sd, so;
    repeat (3) @(posedge sys_clk_in);
    #1 sd = (m_lcs & m_old) | (~m_lcs & ((m_pss & pb_d) | (~m_pss & pa_d)));
    so = (m_lcs & m_oes) | (~m_lcs & ((m_pss & pb_oe) | (~m_pss & pa_oe)));
    chk_pin("pin_out", sd & ~m_ods & plc_pkg::IMPL_MASK, pin_out & plc_pkg::IMPL_MASK);
    chk_pin("pin_oe_out", so & ~(m_ods & sd) & plc_pkg::IMPL_MASK,
      pin_oe_out & plc_pkg::IMPL_MASK);
    chk_pin("pullup_out", m_pus, pullup_out);
  endtask : chk_out

  task do_reset;
    @(posedge sys_clk_in);
    rst_b_in <= 1'b0;
    {m_oes, m_gfs, m_old, m_cim, m_ods, m_pus, m_pss, m_dws} = '0;
    m_lcs = plc_pkg::LCS_RST;
    repeat (3) @(posedge sys_clk_in);
    rst_b_in <= 1'b1;
  endtask : do_reset

  task wait_irq;
    int k;
    for (k = 0; k < 10 && irq_out !== 1'b1; k++) @(posedge sys_clk_in);
    chk_pin("irq_out", 32'h1, {31'h0, irq_out});
    // A wait that ran out has already been counted; end the run here.
    if (irq_out !== 1'b1) give_verdict();
  endtask : wait_irq

  // ----------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------
  initial begin
    {n_errors, cmp_count} = '0;
    {wr_in, rd_in, addr_in, wdata_in, ext_lvl} = '0;
    ext_en = 32'hffff_ffff;
    rst_b_in = 1'b0;
    void'($urandom(32'ha4b62c52));
    {pa_d, pa_oe, pb_d, pb_oe} = {$urandom(), $urandom(), $urandom(), $urandom()};
    do_reset();
    chk_regs();
    rd_chk(8'h3c, 32'h0000_0000);
    rd_chk(8'h4c, 32'h0000_0000);
    // Random traffic over every writable offset, reserved one included.
    for (int i = 0; i < 60; i++) reg_wr(wr_tab[$urandom_range(19, 0)], $urandom());
    chk_regs();
    chk_out();
    // A second reset in mid-run restores every reset value.
    do_reset();
    chk_regs();
    foreach (ex_a[i]) reg_wr(ex_a[i], ex_d[i]);
    chk_regs();
    chk_out();
    // Grouped outputs change in one write; unmasked lines must not move.
    reg_wr(8'h38, 32'hffff_ffff);
    rd_chk(8'h38, 32'h0000_000f);
    reg_wr(8'h38, 32'h0000_000a);
    rd_chk(8'h38, 32'h0000_000a);
    chk_out();
    rd_chk(8'h3c, pin_in & plc_pkg::IMPL_MASK);
    // Change detection: filtered one-cycle pulse on a masked line, plain edge elsewhere.
    repeat (4) @(posedge sys_clk_in);
    // Handing lines to the peripherals raised every line whose peripheral drives
    // high: A on all peripheral lines first, then B on the lines moved to B.
    rd_chk(8'h4c, (pa_oe & pa_d & plc_pkg::PERIPH_MASK) | (pb_oe & pb_d & ex_d[15]));
    rd_chk(8'h4c, 32'h0000_0000);
    @(posedge sys_clk_in);
    ext_lvl[8] <= 1'b1;
    ext_lvl[12] <= 1'b1;
    @(posedge sys_clk_in);
    ext_lvl[8] <= 1'b0;
    wait_irq();
    repeat (4) @(posedge sys_clk_in);
    rd_chk(8'h4c, 32'h0000_1100);
    repeat (3) @(posedge sys_clk_in);
    #1 chk_pin("irq_out", 32'h0, {31'h0, irq_out});
    @(posedge sys_clk_in);
    ext_lvl[12] <= 1'b0;
    repeat (6) @(posedge sys_clk_in);
    #1 chk_pin("irq_out", 32'h0, {31'h0, irq_out});
    rd_chk(8'h4c, 32'h0000_1000);
    give_verdict();
  end
endmodule : test_parallel_io_line_controller
